// *** src/cfg_decode_pkg.sv ***
`default_nettype none
package cfg_decode_pkg;
	// layout of the latched nonvolatile configuration word
	localparam int CFG_WIDTH = 16;
	localparam int GEN_CODE_PROT_BIT = 0;
	localparam int GEN_WRITE_PROT_BIT = 1;
	localparam int TWO_SPEED_BIT = 2;
	localparam int PWM_LOCK_BIT = 3;
	localparam int OSC_SEL_LSB = 4;
	localparam int CSW_MODE_LSB = 7;
	localparam int PIN_MAP_ONE_BIT = 9;
	localparam int OSC_PIN_FN_BIT = 10;
	localparam int POSC_MODE_LSB = 11;
	localparam int WDT_FORCE_BIT = 13;
	localparam int WDT_WIN_DIS_BIT = 14;
	localparam int PLL_LOCK_BIT = 15;

	// start-up oscillator selection codes
	localparam logic [2:0] OSC_FRC = 3'h0;
	localparam logic [2:0] OSC_FRC_DIVN_PLL = 3'h1;
	localparam logic [2:0] OSC_PRI = 3'h2;
	localparam logic [2:0] OSC_PRI_PLL = 3'h3;
	localparam logic [2:0] OSC_RESERVED = 3'h4;
	localparam logic [2:0] OSC_LOW_POWER_INTERNAL_RC = 3'h5;
	localparam logic [2:0] OSC_FRC_DIV16 = 3'h6;
	localparam logic [2:0] OSC_FRC_DIVN = 3'h7;

	// primary oscillator mode codes
	localparam logic [1:0] POSC_EXT_CLK = 2'h0;
	localparam logic [1:0] POSC_XT = 2'h1;
	localparam logic [1:0] POSC_HS = 2'h2;
	localparam logic [1:0] POSC_OFF = 2'h3;

	// clock switching mode
	localparam logic [1:0] CSW_BOTH_ON = 2'h0;

	// register map, byte addresses
	localparam logic [3:0] REG_CFG_WORD = 4'h0;
	localparam logic [3:0] REG_RESET_CTRL = 4'h4;
	localparam logic [3:0] REG_STATE = 4'h8;
	localparam int SOFT_WDT_BIT = 0;
	localparam int PIN_MAP_ARM_BIT = 1;
	localparam logic SOFT_WDT_RESET = 1'h0;

	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [0:0] {
		START_FAST_RC = 1'b0,
		START_TARGET = 1'b1
	} startup_state_type;
endpackage
`default_nettype wire

// *** src/device_config_bit_decode.sv ***
// How it works
// - general code-protect bit 0 protects all program memory; 1 unprotected
// - general write-protect bit 0 blocks program memory writes; 1 allows
// - two-speed bit 1 starts on fast RC, then switches when ready
// - pwm lock bit 1 demands key sequence for pwm writes
// - three-bit oscillator select picks the start-up clock source
// - mode 1x no switching or monitor; 01 switching; 00 both
// - one-shot bit 1 allows a single pin map reconfiguration only
// - pin function bit 1 drives clock out on second pin, unless crystal
// - primary mode: 11 off, 10 high-speed, 01 crystal, 00 external
// - forced watchdog always runs, low-power RC stays, soft bit ignored
// - unforced watchdog follows the soft enable bit, RC may stop
// - window disable bit 1 non-window mode, 0 window mode
// - pll lock enable bit drives pll lock enable
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`default_nettype none
module device_config_bit_decode #(
	parameter int ADDR_WIDTH = 4
) (
	input wire logic clk_i, // system clock
	input wire logic srst_i, // synchronous reset, high
	input wire logic [15:0] cfg_word_i, // nonvolatile configuration bits
	input wire logic target_osc_ready_i, // selected source is stable
	input wire logic pin_map_write_i, // pin map reconfiguration done
	input wire logic awvalid_i, // write address valid
	output logic awready_o, // write address ready
	input wire logic [ADDR_WIDTH-1:0] awaddr_i, // write address
	input wire logic wvalid_i, // write data valid
	output logic wready_o, // write data ready
	input wire logic [31:0] wdata_i, // write data
	input wire logic [3:0] wstrb_i, // write byte strobes
	output logic bvalid_o, // write response valid
	input wire logic bready_i, // write response ready
	output logic [1:0] bresp_o, // write response
	input wire logic arvalid_i, // read address valid
	output logic arready_o, // read address ready
	input wire logic [ADDR_WIDTH-1:0] araddr_i, // read address
	output logic rvalid_o, // read data valid
	input wire logic rready_i, // read data ready
	output logic [31:0] rdata_o, // read data
	output logic [1:0] rresp_o, // read response
	output logic code_protect_o, // program memory code protected
	output logic write_protect_o, // program memory writes blocked
	output logic [2:0] active_osc_o, // clock source in use
	output logic [2:0] target_osc_o, // user-selected source
	output logic osc_use_pll_o, // target source runs through pll
	output logic pwm_key_required_o, // pwm writes need key sequence
	output logic clock_switch_en_o, // clock switching allowed
	output logic fail_safe_en_o, // fail-safe clock monitor on
	output logic pin_map_writable_o, // pin map may be rewritten
	output logic osc_pin_clock_out_o, // second pin drives clock out
	output logic osc_pin_gpio_o, // second pin is digital io
	output logic primary_osc_en_o, // primary oscillator enabled
	output logic [1:0] primary_osc_mode_o, // primary oscillator mode
	output logic wdt_enable_o, // watchdog running
	output logic low_power_internal_rc_keep_on_o, // low-power RC must stay on
	output logic wdt_window_mode_o, // watchdog window mode
	output logic pll_lock_en_o // pll lock enable
);

	////////////////////////////////////////////////////////////////////////
	// configuration capture

	logic [15:0] cfg;
	logic [2:0] osc_sel;
	logic [1:0] csw_mode;
	logic [1:0] posc_mode;
	logic crystal_mode;

	// latch during reset
	// sampled on every rising clock edge while reset is high, so a late-settling word still lands
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cfg <= cfg_word_i;
		end
	end

	assign osc_sel = cfg[cfg_decode_pkg::OSC_SEL_LSB +: 3];
	assign csw_mode = cfg[cfg_decode_pkg::CSW_MODE_LSB +: 2];
	assign posc_mode = cfg[cfg_decode_pkg::POSC_MODE_LSB +: 2];
	assign crystal_mode = (posc_mode == cfg_decode_pkg::POSC_XT) ||
		(posc_mode == cfg_decode_pkg::POSC_HS);

	////////////////////////////////////////////////////////////////////////
	// static decode

	assign code_protect_o = !cfg[cfg_decode_pkg::GEN_CODE_PROT_BIT];
	assign write_protect_o = !cfg[cfg_decode_pkg::GEN_WRITE_PROT_BIT];
	assign pwm_key_required_o = cfg[cfg_decode_pkg::PWM_LOCK_BIT];
	assign clock_switch_en_o = !csw_mode[1];
	assign fail_safe_en_o = (csw_mode == cfg_decode_pkg::CSW_BOTH_ON);
	assign primary_osc_mode_o = posc_mode;
	assign primary_osc_en_o = (posc_mode != cfg_decode_pkg::POSC_OFF);
	// second pin function
	// in crystal modes the pin belongs to the crystal, neither output is on
	assign osc_pin_clock_out_o = !crystal_mode &&
		cfg[cfg_decode_pkg::OSC_PIN_FN_BIT];
	assign osc_pin_gpio_o = !crystal_mode &&
		!cfg[cfg_decode_pkg::OSC_PIN_FN_BIT];
	assign wdt_window_mode_o = !cfg[cfg_decode_pkg::WDT_WIN_DIS_BIT];
	assign pll_lock_en_o = cfg[cfg_decode_pkg::PLL_LOCK_BIT];

	// reserved code guard
	// a reserved code falls back to plain fast RC rather than no clock
	always_comb begin
		target_osc_o = osc_sel;
		if (osc_sel == cfg_decode_pkg::OSC_RESERVED) begin
			target_osc_o = cfg_decode_pkg::OSC_FRC;
		end
	end

	assign osc_use_pll_o = (target_osc_o == cfg_decode_pkg::OSC_PRI_PLL) ||
		(target_osc_o == cfg_decode_pkg::OSC_FRC_DIVN_PLL);

	////////////////////////////////////////////////////////////////////////
	// two-speed start-up

	cfg_decode_pkg::startup_state_type start_state;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			if (cfg_word_i[cfg_decode_pkg::TWO_SPEED_BIT]) begin
				start_state <= cfg_decode_pkg::START_FAST_RC;
			end else begin
				start_state <= cfg_decode_pkg::START_TARGET;
			end
		end else begin
			unique case (start_state)
				cfg_decode_pkg::START_FAST_RC: begin
					if (target_osc_ready_i) begin
						start_state <= cfg_decode_pkg::START_TARGET;
					end
				end
				cfg_decode_pkg::START_TARGET: begin
					start_state <= cfg_decode_pkg::START_TARGET;
				end
			endcase
		end
	end

	assign active_osc_o = (start_state == cfg_decode_pkg::START_FAST_RC) ?
		cfg_decode_pkg::OSC_FRC : target_osc_o;

	////////////////////////////////////////////////////////////////////////
	// pin map one-shot lock

	logic pin_map_used;

	// single reconfiguration
	// only reset clears the lock and software cannot re-arm it, so the lock is final
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pin_map_used <= 1'b0;
		end else if (pin_map_write_i &&
			cfg[cfg_decode_pkg::PIN_MAP_ONE_BIT]) begin
			pin_map_used <= 1'b1;
		end
	end

	assign pin_map_writable_o = !pin_map_used;

	////////////////////////////////////////////////////////////////////////
	// register bus, write side

	logic aw_held;
	logic w_held;
	logic [ADDR_WIDTH-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic soft_wdt;

	assign awready_o = !aw_held && !bvalid_o;
	assign wready_o = !w_held && !bvalid_o;
	assign do_write = aw_held && w_held && !bvalid_o;

	// address and data are taken in either order and paired here
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else if (awvalid_i && awready_o) begin
			aw_held <= 1'b1;
			aw_addr <= awaddr_i;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end else if (wvalid_i && wready_o) begin
			w_held <= 1'b1;
			w_data <= wdata_i;
			w_strb <= wstrb_i;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	// write response, unmapped or read-only words answer decode error
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			bvalid_o <= 1'b0;
			bresp_o <= cfg_decode_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid_o <= 1'b1;
			if (aw_addr == cfg_decode_pkg::REG_RESET_CTRL) begin
				bresp_o <= cfg_decode_pkg::RESP_OKAY;
			end else begin
				bresp_o <= cfg_decode_pkg::RESP_DECERR;
			end
		end else if (bready_i) begin
			bvalid_o <= 1'b0;
		end
	end

	// soft watchdog enable in the reset control register
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			soft_wdt <= cfg_decode_pkg::SOFT_WDT_RESET;
		end else if (do_write && w_strb[0] &&
			aw_addr == cfg_decode_pkg::REG_RESET_CTRL) begin
			soft_wdt <= w_data[cfg_decode_pkg::SOFT_WDT_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// watchdog enable

	assign wdt_enable_o = cfg[cfg_decode_pkg::WDT_FORCE_BIT] || soft_wdt;
	assign low_power_internal_rc_keep_on_o = cfg[cfg_decode_pkg::WDT_FORCE_BIT] || soft_wdt;

	////////////////////////////////////////////////////////////////////////
	// register bus, read side

	logic [31:0] state_word;

	assign arready_o = !rvalid_o;
	assign state_word = {28'h0, wdt_enable_o, pin_map_used,
		start_state == cfg_decode_pkg::START_TARGET, soft_wdt};

	// one read at a time; data is registered with the valid
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rvalid_o <= 1'b0;
			rdata_o <= '0;
			rresp_o <= cfg_decode_pkg::RESP_OKAY;
		end else if (arvalid_i && arready_o) begin
			rvalid_o <= 1'b1;
			rresp_o <= cfg_decode_pkg::RESP_OKAY;
			unique case (araddr_i)
				cfg_decode_pkg::REG_CFG_WORD: rdata_o <= {16'h0, cfg};
				cfg_decode_pkg::REG_RESET_CTRL: begin
					rdata_o <= {31'h0, soft_wdt};
				end
				cfg_decode_pkg::REG_STATE: rdata_o <= state_word;
				default: begin
					rdata_o <= '0;
					rresp_o <= cfg_decode_pkg::RESP_DECERR;
				end
			endcase
		end else if (rready_i) begin
			rvalid_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	property p_cfg_capture;
		@(posedge clk_i) disable iff (srst_i)
		$fell(srst_i) |-> cfg == $past(cfg_word_i);
	endproperty
	a_cfg_capture: assert property (p_cfg_capture)
		else $error("configuration not captured at reset release");

	property p_cfg_hold;
		@(posedge clk_i) disable iff (srst_i)
		!$past(srst_i) |-> $stable(cfg) && $stable(code_protect_o) &&
			$stable(target_osc_o);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold)
		else $error("decoded configuration changed outside reset");

	property p_code_prot;
		@(posedge clk_i) disable iff (srst_i)
		$fell(srst_i) |->
			code_protect_o != $past(cfg_word_i[0]);
	endproperty
	a_code_prot: assert property (p_code_prot)
		else $error("code protect polarity wrong");

	property p_write_prot;
		@(posedge clk_i) disable iff (srst_i)
		write_protect_o |-> !cfg[cfg_decode_pkg::GEN_WRITE_PROT_BIT];
	endproperty
	a_write_prot: assert property (p_write_prot)
		else $error("write protect without cleared bit");

	property p_two_speed;
		@(posedge clk_i) disable iff (srst_i)
		start_state == cfg_decode_pkg::START_FAST_RC && target_osc_ready_i
			|=> active_osc_o == target_osc_o;
	endproperty
	a_two_speed: assert property (p_two_speed)
		else $error("no switch to target after ready");

	property p_fast_start;
		@(posedge clk_i) disable iff (srst_i)
		$fell(srst_i) && cfg[cfg_decode_pkg::TWO_SPEED_BIT] |->
			active_osc_o == cfg_decode_pkg::OSC_FRC;
	endproperty
	a_fast_start: assert property (p_fast_start)
		else $error("two-speed start not on fast RC");

	property p_no_reserved;
		@(posedge clk_i) disable iff (srst_i)
		target_osc_o != cfg_decode_pkg::OSC_RESERVED &&
			(osc_use_pll_o == (target_osc_o == cfg_decode_pkg::OSC_PRI_PLL ||
			target_osc_o == cfg_decode_pkg::OSC_FRC_DIVN_PLL));
	endproperty
	a_no_reserved: assert property (p_no_reserved)
		else $error("oscillator select decode wrong");

	property p_monitor;
		@(posedge clk_i) disable iff (srst_i)
		fail_safe_en_o |-> clock_switch_en_o;
	endproperty
	a_monitor: assert property (p_monitor)
		else $error("monitor enabled without clock switching");

	property p_one_shot;
		@(posedge clk_i) disable iff (srst_i)
		pin_map_write_i && cfg[cfg_decode_pkg::PIN_MAP_ONE_BIT] |=>
			!pin_map_writable_o [*3];
	endproperty
	a_one_shot: assert property (p_one_shot)
		else $error("pin map reopened after one-shot write");

	property p_osc_pin;
		@(posedge clk_i) disable iff (srst_i)
		crystal_mode |-> !osc_pin_clock_out_o && !osc_pin_gpio_o;
	endproperty
	a_osc_pin: assert property (p_osc_pin)
		else $error("second pin taken in crystal mode");

	property p_forced_wdt;
		@(posedge clk_i) disable iff (srst_i)
		cfg[cfg_decode_pkg::WDT_FORCE_BIT] && do_write |=>
			wdt_enable_o && low_power_internal_rc_keep_on_o;
	endproperty
	a_forced_wdt: assert property (p_forced_wdt)
		else $error("forced watchdog stopped by software");

	property p_soft_wdt;
		@(posedge clk_i) disable iff (srst_i)
		!cfg[cfg_decode_pkg::WDT_FORCE_BIT] && do_write && w_strb[0] &&
			aw_addr == cfg_decode_pkg::REG_RESET_CTRL |=>
			wdt_enable_o == $past(w_data[0]);
	endproperty
	a_soft_wdt: assert property (p_soft_wdt)
		else $error("watchdog does not follow soft enable");

endmodule
`default_nettype wire

// *** tb/device_config_bit_decode_tb.sv ***
`default_nettype none
module device_config_bit_decode_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0, srst_i = 1'b1;
	logic [15:0] cfg_word_i = 16'hffff;
	logic target_osc_ready_i = 1'b0, pin_map_write_i = 1'b0;
	logic awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0;
	logic arvalid_i = 1'b0, rready_i = 1'b0;
	logic [3:0] awaddr_i = 4'h0, araddr_i = 4'h0, wstrb_i = 4'h0;
	logic [31:0] wdata_i = 32'h0;
	logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
	logic [1:0] bresp_o, rresp_o, primary_osc_mode_o;
	logic [31:0] rdata_o;
	logic [2:0] active_osc_o, target_osc_o;
	logic code_protect_o, write_protect_o, osc_use_pll_o, pwm_key_required_o;
	logic clock_switch_en_o, fail_safe_en_o, pin_map_writable_o;
	logic osc_pin_clock_out_o, osc_pin_gpio_o, primary_osc_en_o;
	logic wdt_enable_o, low_power_internal_rc_keep_on_o, wdt_window_mode_o, pll_lock_en_o;
	int n_errors = 0, check_count = 0, seed = 16;
	logic [15:0] c;

	device_config_bit_decode u_device_config_bit_decode (
		.clk_i, .srst_i, .cfg_word_i, .target_osc_ready_i, .pin_map_write_i,
		.awvalid_i, .awready_o, .awaddr_i, .wvalid_i, .wready_o, .wdata_i,
		.wstrb_i, .bvalid_o, .bready_i, .bresp_o, .arvalid_i, .arready_o,
		.araddr_i, .rvalid_o, .rready_i, .rdata_o, .rresp_o, .code_protect_o,
		.write_protect_o, .active_osc_o, .target_osc_o, .osc_use_pll_o,
		.pwm_key_required_o, .clock_switch_en_o, .fail_safe_en_o,
		.pin_map_writable_o, .osc_pin_clock_out_o, .osc_pin_gpio_o,
		.primary_osc_en_o, .primary_osc_mode_o, .wdt_enable_o,
		.low_power_internal_rc_keep_on_o, .wdt_window_mode_o, .pll_lock_en_o
	);

	// 100 MHz system clock
	initial begin
		forever #5 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// handshakes are sampled at the falling edge, where nothing moves
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic ha, hw, hb;
		@(posedge clk_i);
		awaddr_i <= a;
		wdata_i <= d;
		wstrb_i <= 4'hf;
		awvalid_i <= 1'b1;
		wvalid_i <= 1'b1;
		bready_i <= 1'b1;
		hb = 1'b0;
		for (int n = 0; n < 50 && !hb; n++) begin
			@(negedge clk_i);
			ha = awvalid_i && awready_o;
			hw = wvalid_i && wready_o;
			hb = bvalid_o;
			r = bresp_o;
			@(posedge clk_i);
			if (ha) awvalid_i <= 1'b0;
			if (hw) wvalid_i <= 1'b0;
			if (hb) bready_i <= 1'b0;
		end
		if (!hb) begin
			n_errors++;
			final_report();
		end
	endtask

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ha, hr;
		@(posedge clk_i);
		araddr_i <= a;
		arvalid_i <= 1'b1;
		rready_i <= 1'b1;
		hr = 1'b0;
		for (int n = 0; n < 50 && !hr; n++) begin
			@(negedge clk_i);
			ha = arvalid_i && arready_o;
			hr = rvalid_o;
			d = rdata_o;
			r = rresp_o;
			@(posedge clk_i);
			if (ha) arvalid_i <= 1'b0;
			if (hr) rready_i <= 1'b0;
		end
		if (!hr) begin
			n_errors++;
			final_report();
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// one configuration: reset, decode, start-up, pin map, watchdog, bus
	task automatic run_case(input logic [15:0] cw);
		logic [1:0] r;
		logic [31:0] d, wd;
		logic [2:0] t;
		logic xt;
		@(posedge clk_i);
		srst_i <= 1'b1;
		cfg_word_i <= cw;
		target_osc_ready_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		srst_i <= 1'b0;
		// input flips after release: outputs must not follow it
		cfg_word_i <= ~cw;
		@(negedge clk_i);
		// reserved select code reads back as plain fast rc
		t = (cw[6:4] == 3'h4) ? 3'h0 : cw[6:4];
		xt = cw[12:11] == 2'h1 || cw[12:11] == 2'h2;
		check("code_protect", code_protect_o, !cw[0]);
		check("write_protect", write_protect_o, !cw[1]);
		check("active_osc", active_osc_o, cw[2] ? 3'h0 : t);
		check("target_osc", target_osc_o, t);
		check("use_pll", osc_use_pll_o, t == 3'h3 || t == 3'h1);
		check("pwm_key", pwm_key_required_o, cw[3]);
		check("clock_switch", clock_switch_en_o, !cw[8]);
		check("fail_safe", fail_safe_en_o, cw[8:7] == 2'h0);
		check("pin_map_wr", pin_map_writable_o, 1'b1);
		check("osc_pin_clk", osc_pin_clock_out_o, cw[10] && !xt);
		check("osc_pin_gpio", osc_pin_gpio_o, !cw[10] && !xt);
		check("primary_en", primary_osc_en_o, cw[12:11] != 2'h3);
		check("primary_mode", primary_osc_mode_o, cw[12:11]);
		check("wdt_enable", wdt_enable_o, cw[13]);
		check("low_power_internal_rc_on", low_power_internal_rc_keep_on_o, cw[13]);
		check("window_mode", wdt_window_mode_o, !cw[14]);
		check("pll_lock", pll_lock_en_o, cw[15]);
		axi_rd(cfg_decode_pkg::REG_CFG_WORD, d, r);
		check("cfg_read", d, {16'h0, cw});
		check("cfg_resp", r, cfg_decode_pkg::RESP_OKAY);
		// selected source becomes ready: switch over one cycle later
		target_osc_ready_i <= 1'b1;
		@(posedge clk_i);
		@(negedge clk_i);
		check("osc_switched", active_osc_o, t);
		@(posedge clk_i);
		pin_map_write_i <= 1'b1;
		@(posedge clk_i);
		pin_map_write_i <= 1'b0;
		@(negedge clk_i);
		check("pin_map_locked", pin_map_writable_o, !cw[9]);
		// software watchdog bit; upper data bits are ignored
		wd = $random(seed);
		wd[0] = 1'b1;
		axi_wr(cfg_decode_pkg::REG_RESET_CTRL, wd, r);
		check("soft_set_resp", r, cfg_decode_pkg::RESP_OKAY);
		@(negedge clk_i);
		check("wdt_soft_on", wdt_enable_o, 1'b1);
		check("low_power_internal_rc_soft_on", low_power_internal_rc_keep_on_o, 1'b1);
		axi_rd(cfg_decode_pkg::REG_RESET_CTRL, d, r);
		check("soft_read", d, 32'h1);
		wd[0] = 1'b0;
		axi_wr(cfg_decode_pkg::REG_RESET_CTRL, wd, r);
		@(negedge clk_i);
		check("wdt_soft_off", wdt_enable_o, cw[13]);
		check("low_power_internal_rc_soft_off", low_power_internal_rc_keep_on_o, cw[13]);
		// read-only and unmapped places
		axi_wr(cfg_decode_pkg::REG_CFG_WORD, wd, r);
		check("ro_write_resp", r, cfg_decode_pkg::RESP_DECERR);
		axi_rd(4'hc, d, r);
		check("unmapped_data", d, 32'h0);
		check("unmapped_resp", r, cfg_decode_pkg::RESP_DECERR);
		axi_rd(cfg_decode_pkg::REG_CFG_WORD, d, r);
		check("cfg_held", d, {16'h0, cw});
		check("cp_held", code_protect_o, !cw[0]);
	endtask

	////////////////////////////////////////////////////////////////////////
	// every select code except reserved 4, every mode and primary code
	initial begin
		for (int i = 0; i < 16; i++) begin
			c = 16'($random(seed));
			c[6:4] = (i[2:0] == 3'h4) ? 3'h7 : i[2:0];
			c[8:7] = i[1:0];
			c[12:11] = i[3:2];
			run_case(c);
			$display("test %0d done, config %h", i, c);
		end
		final_report();
	end
endmodule
`default_nettype wire
